/* rtl/qbp_bit.sv */
// qbp_bit: one quasi-bidirectional port line with latch, pin sync and pull-ups
// assumes the pad resolves pin_out/pin_oe with a weak pull-up switched by pu_weak
`timescale 1ns/1ps
module qbp_bit #(
   parameter int ASSIST_CLKS = qbp_pkg::ASSIST_CLKS
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic port_rst,
   input  wire logic wr_en,
   input  wire logic wr_val,
   input  wire logic alt_out,
   input  wire logic exempt,
   input  wire logic analog_off,
   input  wire logic pin_in,
   output logic      latch,
   output logic      pin_sync,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      pu_weak
);
   localparam int AW = $clog2(ASSIST_CLKS + 1);

   logic          meta;
   logic [AW-1:0] assist;
   wire           rise      = wr_en & wr_val & ~latch;
   // latch one lets the alternate output decide the level
   wire           drive_val = exempt ? alt_out : (latch & alt_out);
   wire           assist_on = (assist != '0);

   // latch, reset to one so the line is an input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)       latch <= 1'b1;
      else if (port_rst) latch <= 1'b1;
      else if (wr_en)    latch <= wr_val;
   end

   // strong assist after a zero-to-one latch change, never in reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)        assist <= '0;
      else if (port_rst)  assist <= '0;
      else if (rise)      assist <= AW'(ASSIST_CLKS);
      else if (assist_on) assist <= assist - AW'(1);
   end

   // pin read path through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta     <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         meta     <= pin_in;
         pin_sync <= meta;
      end
   end

   // pad controls; a one only drives while the assist runs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= 1'b1;
         pin_oe  <= 1'b0;
         pu_weak <= 1'b1;
      end else begin
         pin_out <= drive_val & ~port_rst;
         pin_oe  <= ~drive_val | (assist_on & ~port_rst);
         pu_weak <= ~analog_off;
      end
   end
endmodule

/* rtl/qbp_pkg.sv */
// qbp_pkg: shared types and constants for the quasi-bidirectional port block
// assumes a single core clock that also serves as the oscillator period base
package qbp_pkg;

   // widths of the two ports
   localparam int EIGHT_W = 8;
   localparam int TWO_W   = 2;

   // clock and timing figures, times in ns
   localparam int CLK_NS        = 40;
   localparam int OSC_PERIOD_NS = 40;
   localparam int ASSIST_OSC    = 2;
   localparam int ASSIST_NS     = ASSIST_OSC * OSC_PERIOD_NS;
   // least time, so round up
   localparam int ASSIST_CLKS   = (ASSIST_NS + CLK_NS - 1) / CLK_NS;

   // reset pin qualification: machine cycles held high
   localparam int MC_CLKS       = 12;
   localparam int RST_MC        = 2;
   localparam int RST_HOLD_CLKS = MC_CLKS * RST_MC;

   // latch reset value: all ones, pins start as inputs
   localparam logic [7:0] LATCH_RST = 8'hFF;
   // bits whose alternate output ignores the latch (serial transmit)
   localparam logic [7:0] ALT_EXEMPT_8 = 8'h02;
   // eight-bit port bit positions
   localparam int B_RXD  = 0;
   localparam int B_TXD  = 1;
   localparam int B_IRQ0 = 2;
   localparam int B_IRQ1 = 3;
   localparam int B_CNT0 = 4;
   localparam int B_CNT1 = 5;
   // two-bit port bit positions
   localparam int B_CTX  = 0;
   localparam int B_CRX  = 1;
   // port select codes
   localparam logic PSEL_EIGHT = 1'b0;
   localparam logic PSEL_TWO   = 1'b1;

   // one cpu access to the port latches
   typedef struct packed {
      logic       wr;
      logic       rd_latch;
      logic       rd_pin;
      logic       bit_wr;
      logic       port_sel;
      logic [2:0] bit_idx;
      logic       bit_val;
      logic [7:0] wdata;
   } qbp_cpu_req_t;

   // answer to a read
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } qbp_cpu_rsp_t;

   // operation chosen after priority
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0,
      OP_BITWR  = 4'h1,
      OP_WR     = 4'h2,
      OP_RDLAT  = 4'h4,
      OP_RDPIN  = 4'h8
   } qbp_op_t;

endpackage

/* rtl/qbp_ports.sv */
// qbp_ports: latch logic of the eight-bit and two-bit quasi-bidirectional ports
// assumes the cpu issues one access per cycle and pins are asynchronous
//
// Functional notes
// - eight-bit port, per-bit latch, read and pull-up
// - two-bit port built from the same cell
// - latch one releases the low drive
// - alternate functions need latch one, transmit exempt
// - bit0 serial receive, bit1 transmit, 6-7 plain
// - bits 2-5 feed interrupts, gates and counters
// - two-bit port carries can transmit and receive
// - reset pin needs two machine cycles high
// - write strobe loads bus data into latches
// - separate read-latch and read-pin paths
// - read-modify-write reads the latch, not pin
// - bit ops rewrite the whole latch byte
// - latch one turns off the pull-down drive
// - set latch lets alternate output steer pin
// - every line independently input or output
// - pull-up can be cut for analog use
// - reset loads ones into every latch
// - two-period strong assist after latch rise
`timescale 1ns/1ps
module qbp_ports #(
   parameter int           EIGHT_W     = qbp_pkg::EIGHT_W,
   parameter int           TWO_W       = qbp_pkg::TWO_W,
   parameter int           RST_HOLD    = qbp_pkg::RST_HOLD_CLKS,
   parameter int           ASSIST_CLKS = qbp_pkg::ASSIST_CLKS,
   parameter bit           ANALOG_CAP  = 1'b0,
   parameter logic [7:0]   ALT_EXEMPT  = qbp_pkg::ALT_EXEMPT_8
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  rst_pin,
   // cpu side
   input  wire qbp_pkg::qbp_cpu_req_t cpu_req,
   output qbp_pkg::qbp_cpu_rsp_t      cpu_rsp,
   output logic                       core_rst,
   // analog select, only honoured on an analog-capable build
   input  wire logic [EIGHT_W-1:0]    analog_sel,
   // alternate function outputs toward the pins
   input  wire logic                  uart_rxd_drive,
   input  wire logic                  uart_txd_out,
   input  wire logic                  can_tx_line,
   // alternate function inputs from the pins
   output logic                       uart_rxd_in,
   output logic                       ext_irq0_in,
   output logic                       ext_irq1_in,
   output logic                       timer0_gate_in,
   output logic                       timer1_gate_in,
   output logic                       timer0_count_in,
   output logic                       timer1_count_in,
   output logic                       can_rx_line,
   // latch contents
   output logic [EIGHT_W-1:0]         eight_bit_port,
   output logic [TWO_W-1:0]           two_bit_port,
   // eight-bit port pads
   input  wire logic [EIGHT_W-1:0]    p8_in,
   output logic [EIGHT_W-1:0]         p8_out,
   output logic [EIGHT_W-1:0]         p8_oe,
   output logic [EIGHT_W-1:0]         p8_pu_weak,
   // two-bit port pads
   input  wire logic [TWO_W-1:0]      p2_in,
   output logic [TWO_W-1:0]           p2_out,
   output logic [TWO_W-1:0]           p2_oe,
   output logic [TWO_W-1:0]           p2_pu_weak
);

   logic               port_rst;
   logic [EIGHT_W-1:0] sync8;
   logic [TWO_W-1:0]   sync2;
   qbp_pkg::qbp_op_t   op;

   // reset pin qualification
   qbp_rst_filter #(
      .HOLD_CLKS (RST_HOLD)
   ) u_rst (
      .clk      (clk),
      .arst_n   (arst_n),
      .rst_pin  (rst_pin),
      .port_rst (port_rst)
   );

   // op priority: bit write, byte write, latch read, pin read
   assign op = cpu_req.bit_wr   ? qbp_pkg::OP_BITWR :
               cpu_req.wr       ? qbp_pkg::OP_WR    :
               cpu_req.rd_latch ? qbp_pkg::OP_RDLAT :
               cpu_req.rd_pin   ? qbp_pkg::OP_RDPIN :
                                  qbp_pkg::OP_NONE;

   // port decode
   wire sel8 = (cpu_req.port_sel == qbp_pkg::PSEL_EIGHT);
   wire sel2 = (cpu_req.port_sel == qbp_pkg::PSEL_TWO);

   // latch bytes as the cpu sees them, upper bits zero
   wire [7:0] lat8_byte = 8'(eight_bit_port);
   wire [7:0] lat2_byte = 8'(two_bit_port);
   wire [7:0] pin8_byte = 8'(sync8);
   wire [7:0] pin2_byte = 8'(sync2);
   wire [7:0] lat_byte  = sel8 ? lat8_byte : lat2_byte;
   wire [7:0] pin_byte  = sel8 ? pin8_byte : pin2_byte;

   // bit op: take the whole latch byte, change one bit
   wire [7:0] bit_mask  = 8'h01 << cpu_req.bit_idx;
   wire [7:0] bit_byte  = (lat_byte & ~bit_mask) |
                          (cpu_req.bit_val ? bit_mask : 8'h00);
   // a bit index past the port width changes nothing
   wire       bit_ok    = sel8 ? 1'b1 : (32'(cpu_req.bit_idx) < TWO_W);

   // write data and strobes for the latches
   wire       do_wr     = (op == qbp_pkg::OP_WR) |
                          ((op == qbp_pkg::OP_BITWR) & bit_ok);
   wire [7:0] wr_byte   = (op == qbp_pkg::OP_BITWR) ? bit_byte : cpu_req.wdata;
   wire       wr8       = do_wr & sel8 & ~port_rst;
   wire       wr2       = do_wr & sel2 & ~port_rst;

   // alternate outputs; idle functions sit at one so the latch rules
   wire [EIGHT_W-1:0] alt8;
   wire [TWO_W-1:0]   alt2;
   wire [EIGHT_W-1:0] exempt8 = EIGHT_W'(ALT_EXEMPT);

   generate
      for (genvar i = 0; i < EIGHT_W; i++) begin : g_alt8
         if (i == qbp_pkg::B_RXD) begin : g_rxd
            assign alt8[i] = uart_rxd_drive;
         end else if (i == qbp_pkg::B_TXD) begin : g_txd
            assign alt8[i] = uart_txd_out;
         end else begin : g_plain
            assign alt8[i] = 1'b1;
         end
      end
      for (genvar j = 0; j < TWO_W; j++) begin : g_alt2
         if (j == qbp_pkg::B_CTX) begin : g_ctx
            assign alt2[j] = can_tx_line;
         end else begin : g_crx
            assign alt2[j] = 1'b1;
         end
      end
   endgenerate

   // analog disconnect only where the port can be analog
   wire [EIGHT_W-1:0] ana_off = ANALOG_CAP ? analog_sel : '0;

   // eight-bit port lines
   generate
      for (genvar i = 0; i < EIGHT_W; i++) begin : g_p8
         qbp_bit #(
            .ASSIST_CLKS (ASSIST_CLKS)
         ) u_bit (
            .clk        (clk),
            .arst_n     (arst_n),
            .port_rst   (port_rst),
            .wr_en      (wr8),
            .wr_val     (wr_byte[i]),
            .alt_out    (alt8[i]),
            .exempt     (exempt8[i]),
            .analog_off (ana_off[i]),
            .pin_in     (p8_in[i]),
            .latch      (eight_bit_port[i]),
            .pin_sync   (sync8[i]),
            .pin_out    (p8_out[i]),
            .pin_oe     (p8_oe[i]),
            .pu_weak    (p8_pu_weak[i])
         );
      end
   endgenerate

   // two-bit port lines, same cell
   generate
      for (genvar j = 0; j < TWO_W; j++) begin : g_p2
         qbp_bit #(
            .ASSIST_CLKS (ASSIST_CLKS)
         ) u_bit (
            .clk        (clk),
            .arst_n     (arst_n),
            .port_rst   (port_rst),
            .wr_en      (wr2),
            .wr_val     (wr_byte[j]),
            .alt_out    (alt2[j]),
            .exempt     (1'b0),
            .analog_off (1'b0),
            .pin_in     (p2_in[j]),
            .latch      (two_bit_port[j]),
            .pin_sync   (sync2[j]),
            .pin_out    (p2_out[j]),
            .pin_oe     (p2_oe[j]),
            .pu_weak    (p2_pu_weak[j])
         );
      end
   endgenerate

   // read answer: latch path or pin path
   wire       rd_any  = (op == qbp_pkg::OP_RDLAT) | (op == qbp_pkg::OP_RDPIN);
   wire [7:0] rd_data = (op == qbp_pkg::OP_RDLAT) ? lat_byte : pin_byte;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_rsp <= '0;
      end else begin
         cpu_rsp.valid <= rd_any & ~port_rst;
         cpu_rsp.data  <= rd_any ? rd_data : 8'h00;
      end
   end

   // alternate inputs need a one in the latch; gating keeps a
   // low-driven line from posing as an external event
   wire [EIGHT_W-1:0] in8 = sync8 & eight_bit_port;
   wire [TWO_W-1:0]   in2 = sync2 & two_bit_port;

   // alternate inputs registered so every output is a flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         uart_rxd_in     <= 1'b1;
         ext_irq0_in     <= 1'b1;
         ext_irq1_in     <= 1'b1;
         timer0_gate_in  <= 1'b1;
         timer1_gate_in  <= 1'b1;
         timer0_count_in <= 1'b1;
         timer1_count_in <= 1'b1;
         can_rx_line     <= 1'b1;
      end else begin
         uart_rxd_in     <= in8[qbp_pkg::B_RXD];
         ext_irq0_in     <= in8[qbp_pkg::B_IRQ0];
         ext_irq1_in     <= in8[qbp_pkg::B_IRQ1];
         timer0_gate_in  <= in8[qbp_pkg::B_IRQ0];
         timer1_gate_in  <= in8[qbp_pkg::B_IRQ1];
         timer0_count_in <= in8[qbp_pkg::B_CNT0];
         timer1_count_in <= in8[qbp_pkg::B_CNT1];
         can_rx_line     <= in2[qbp_pkg::B_CRX];
      end
   end

   // qualified reset out to the core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) core_rst <= 1'b1;
      else         core_rst <= port_rst;
   end

endmodule

/* rtl/qbp_rst_filter.sv */
// qbp_rst_filter: qualifies the active-high reset pin by its hold time
// assumes the pin is asynchronous to clk; arst_n is the power-on reset
`timescale 1ns/1ps
module qbp_rst_filter #(
   parameter int HOLD_CLKS = qbp_pkg::RST_HOLD_CLKS
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic rst_pin,
   output logic      port_rst
);
   localparam int CW = $clog2(HOLD_CLKS + 1);

   logic          sync1;
   logic          sync2;
   logic [CW-1:0] cnt;
   wire           held = (cnt == CW'(HOLD_CLKS - 1));

   // two flops before anything looks at the pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= rst_pin;
         sync2 <= sync1;
      end
   end

   // a short glitch restarts the count and never resets
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt      <= '0;
         port_rst <= 1'b1;
      end else if (!sync2) begin
         cnt      <= '0;
         port_rst <= 1'b0;
      end else if (held) begin
         port_rst <= 1'b1;
      end else begin
         cnt <= cnt + CW'(1);
      end
   end
endmodule

/* testbench/qbp_pins_model.sv */
// qbp_pins_model: board side of both ports, pull-ups and outside drivers
// assumes the bench picks which pins an outside source pulls low
`timescale 1ns/1ps
module qbp_pins_model (
   input  wire logic       clk,
   input  wire logic [7:0] p8_out,
   input  wire logic [7:0] p8_oe,
   input  wire logic [7:0] p8_pu_weak,
   input  wire logic [1:0] p2_out,
   input  wire logic [1:0] p2_oe,
   input  wire logic [1:0] p2_pu_weak,
   input  wire logic [7:0] ext8,
   input  wire logic [1:0] ext2,
   output logic      [7:0] p8_in,
   output logic      [1:0] p2_in
);
   logic flt = 1'b0; // level of a pin that nobody holds
   // unheld pins wander, so a stale level never reads back by luck
   always @(posedge clk) flt <= ~flt;
   // active drive wins; a released pin rests on its pull-up unless pulled low
   assign p8_in = (p8_oe & p8_out) | (~p8_oe & ~ext8 & (p8_pu_weak | {8{flt}}));
   assign p2_in = (p2_oe & p2_out) | (~p2_oe & ~ext2 & (p2_pu_weak | {2{flt}}));
endmodule

/* testbench/qbp_ports_monitor.sv */
// qbp_ports_monitor: concurrent checks at the port latch block's ports
// assumes one clock domain; bound into every qbp_ports instance
`timescale 1ns/1ps
module qbp_ports_monitor #(
   parameter int RST_HOLD = 24
) (
   input wire logic                  clk,
   input wire logic                  arst_n,
   input wire logic                  rst_pin,
   input wire qbp_pkg::qbp_cpu_req_t cpu_req,
   input wire qbp_pkg::qbp_cpu_rsp_t cpu_rsp,
   input wire logic                  core_rst,
   input wire logic                  uart_txd_out,
   input wire logic                  ext_irq0_in,
   input wire logic                  timer0_gate_in,
   input wire logic [7:0]            eight_bit_port,
   input wire logic [1:0]            two_bit_port,
   input wire logic [7:0]            p8_in,
   input wire logic [7:0]            p8_out,
   input wire logic [7:0]            p8_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] hi_cnt;
   logic [7:0] bit_next;
   logic [7:0] wdata;
   // decoded op after priority, eight-bit port only
   wire sel8  = cpu_req.port_sel == qbp_pkg::PSEL_EIGHT;
   wire op_bw = cpu_req.bit_wr && sel8;
   wire op_wr = cpu_req.wr && !cpu_req.bit_wr && sel8;
   wire op_rl = cpu_req.rd_latch && !cpu_req.wr && !cpu_req.bit_wr && sel8;
   wire op_rp = cpu_req.rd_pin && !cpu_req.rd_latch && !cpu_req.wr && !cpu_req.bit_wr && sel8;
   assign wdata    = cpu_req.wdata;
   assign bit_next = (eight_bit_port & ~(8'h01 << cpu_req.bit_idx)) | ({7'h00, cpu_req.bit_val} << cpu_req.bit_idx);
   // saturating run length of the reset pin, so long holds never wrap
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         hi_cnt <= 8'h00;
      else if (!rst_pin)
         hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF)
         hi_cnt <= hi_cnt + 8'h01;
   end
   sequence taken_s(logic op);
      op ##1 !core_rst;
   endsequence
   sequence rise7_s;
      $rose(eight_bit_port[7]) && !core_rst;
   endsequence
   sequence assist7_s;
      (p8_oe[7] && p8_out[7]) [*2] ##1 !p8_oe[7];
   endsequence
   latch_read_a: assert property (taken_s(op_rl) |-> cpu_rsp.valid && cpu_rsp.data == $past(eight_bit_port))
      else $error("latch read returned wrong data");
   byte_write_a: assert property (taken_s(op_wr) |-> eight_bit_port == $past(wdata))
      else $error("byte write not loaded into latch");
   bit_write_a: assert property (taken_s(op_bw) |-> eight_bit_port == $past(bit_next))
      else $error("bit write changed other latch bits");
   pin_read_a: assert property ($stable(p8_in) [*4] ##0 taken_s(op_rp) |-> cpu_rsp.valid && cpu_rsp.data == $past(p8_in))
      else $error("pin read returned wrong data");
   reset_ones_a: assert property (core_rst |-> eight_bit_port == 8'hFF && two_bit_port == 2'h3)
      else $error("latches not all ones in reset");
   assist_pulse_a: assert property (rise7_s |=> assist7_s)
      else $error("strong assist not two cycles after latch rise");
   drive_low_a: assert property (!eight_bit_port[6] ##1 !eight_bit_port[6] |-> p8_oe[6] && !p8_out[6])
      else $error("latch zero does not drive pin low");
   txd_exempt_a: assert property (taken_s(!uart_txd_out) |-> p8_oe[1] && !p8_out[1])
      else $error("transmit output not on pin");
   alt_gate_a: assert property (taken_s(!eight_bit_port[2]) |-> !ext_irq0_in && !timer0_gate_in)
      else $error("interrupt input not gated by latch");
   rst_qual_a: assert property ($rose(core_rst) |-> hi_cnt >= RST_HOLD)
      else $error("reset taken from a short pulse");
   rst_bound_a: assert property (hi_cnt == 8'(RST_HOLD + 6) |-> core_rst)
      else $error("long reset pulse not taken");
endmodule

bind qbp_ports qbp_ports_monitor #(.RST_HOLD(RST_HOLD)) mon (.clk, .arst_n, .rst_pin, .cpu_req, .cpu_rsp,
   .core_rst, .uart_txd_out, .ext_irq0_in, .timer0_gate_in, .eight_bit_port, .two_bit_port, .p8_in, .p8_out, .p8_oe);

/* testbench/tb.sv */
// tb: random and directed checks of the port latch block
// assumes the pins model stands for the board; reset hold shortened to 4
`timescale 1ns/1ps
module tb;
   localparam int HOLD = 4;
   logic                  clk = 1'b0;
   logic                  arst_n = 1'b0;
   logic                  rst_pin = 1'b0;
   qbp_pkg::qbp_cpu_req_t cpu_req = '0;
   qbp_pkg::qbp_cpu_rsp_t cpu_rsp;
   logic                  core_rst, a_rxd, a_i0, a_i1, a_g0, a_g1, a_c0, a_c1, a_crx;
   logic                  rxd_drv = 1'b1, txd = 1'b1, ctx = 1'b1;
   logic [7:0]            analog_sel = 8'h00, ext8 = 8'h00, e8, lat8, p8_in, p8_out, p8_oe, p8_pu;
   logic [1:0]            ext2 = 2'h0, e2, lat2, p2_in, p2_out, p2_oe, p2_pu;
   int                    errors = 0, checks = 0;
   always #20 clk = ~clk;
   qbp_ports #(.RST_HOLD(HOLD)) uut (.clk, .arst_n, .rst_pin, .cpu_req, .cpu_rsp, .core_rst, .analog_sel,
      .uart_rxd_drive(rxd_drv), .uart_txd_out(txd), .can_tx_line(ctx), .uart_rxd_in(a_rxd), .ext_irq0_in(a_i0),
      .ext_irq1_in(a_i1), .timer0_gate_in(a_g0), .timer1_gate_in(a_g1), .timer0_count_in(a_c0),
      .timer1_count_in(a_c1), .can_rx_line(a_crx), .eight_bit_port(lat8), .two_bit_port(lat2), .p8_in,
      .p8_out, .p8_oe, .p8_pu_weak(p8_pu), .p2_in, .p2_out, .p2_oe, .p2_pu_weak(p2_pu));
   qbp_pins_model pins (.clk, .p8_out, .p8_oe, .p8_pu_weak(p8_pu), .p2_out, .p2_oe, .p2_pu_weak(p2_pu),
      .ext8, .ext2, .p8_in, .p2_in);
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // expected pin levels; transmit ignores its latch
   function automatic logic [7:0] pin8(input logic [7:0] l);
      logic [7:0] drv;
      drv = l;
      drv[0] = l[0] & rxd_drv;
      drv[1] = txd;
      return drv & ~ext8;
   endfunction
   task automatic op(input qbp_pkg::qbp_cpu_req_t r, output logic v, output logic [7:0] d);
      @(posedge clk) cpu_req <= r;
      @(posedge clk) cpu_req <= '0;
      #1;
      v = cpu_rsp.valid;
      d = cpu_rsp.data;
   endtask
   // bounded wait for the core to leave reset
   task automatic wait_run;
      int i;
      for (i = 0; i < 40 && core_rst !== 1'b0; i++) @(posedge clk) #1;
      if (core_rst !== 1'b0) begin
         errors++;
         complete_run();
      end
   endtask
   // reset pin held n+1 cycles, n+3 on a long hold, which also tries a write that must be refused
   task automatic pulse(input int n);
      int i;
      logic hit, v;
      logic [7:0] d;
      qbp_pkg::qbp_cpu_req_t w;
      hit = 1'b0;
      w = '0;
      w.wr = 1'b1;
      @(posedge clk) rst_pin <= 1'b1;
      for (i = 0; i < n; i++) begin
         @(posedge clk) #1;
         hit |= core_rst;
      end
      if (n > HOLD)
         op(w, v, d);
      @(posedge clk) rst_pin <= 1'b0;
      // a taken reset reloads every latch with ones
      if (n > HOLD) begin
         e8 = 8'hFF;
         e2 = 2'h3;
      end
      wait_run();
      check("core_rst", {7'h00, hit}, {7'h00, n > HOLD});
      check("latch8", lat8, e8);
      check("latch2", {6'h00, lat2}, {6'h00, e2});
   endtask
   // one access with fresh pin and alternate-output conditions
   task automatic step(input qbp_pkg::qbp_cpu_req_t r);
      logic v, vx;
      logic [7:0] d, dx, pl, pe, p8;
      logic [1:0] p2;
      @(posedge clk);
      ext8 <= 8'($urandom);
      ext2 <= 2'($urandom);
      {rxd_drv, txd, ctx} <= 3'($urandom);
      analog_sel <= 8'($urandom);
      repeat (3) @(posedge clk);
      p2 = e2 & {1'b1, ctx} & ~ext2;
      pl = r.port_sel ? {6'h00, e2} : e8;
      pe = r.port_sel ? {6'h00, p2} : pin8(e8);
      vx = 1'b0;
      dx = 8'h00;
      if (r.bit_wr) begin
         if (!r.port_sel || r.bit_idx < 3'h2)
            pl[r.bit_idx] = r.bit_val;
      end else if (r.wr)
         pl = r.port_sel ? {6'h00, r.wdata[1:0]} : r.wdata;
      else if (r.rd_latch || r.rd_pin) begin
         vx = 1'b1;
         dx = r.rd_latch ? pl : pe;
      end
      if (r.port_sel)
         e2 = pl[1:0];
      else
         e8 = pl;
      op(r, v, d);
      check("rsp_valid", {7'h00, v}, {7'h00, vx});
      check("rsp_data", d, dx);
      check("latch8", lat8, e8);
      check("latch2", {6'h00, lat2}, {6'h00, e2});
      repeat (6) @(posedge clk) #1;
      p8 = pin8(e8) & e8;
      p2 = e2 & {1'b1, ctx} & ~ext2;
      pe = {p8[0], p8[2], p8[3], p8[2], p8[3], p8[4], p8[5], p2[1]};
      check("alt_in", {a_rxd, a_i0, a_i1, a_g0, a_g1, a_c0, a_c1, a_crx}, pe);
      // no analog use on these ports, so the pull-ups stay on whatever is asked
      check("pull_up8", p8_pu, 8'hFF);
      check("pull_up2", {6'h00, p2_pu}, 8'h03);
   endtask
   initial begin
      qbp_pkg::qbp_cpu_req_t r;
      logic [7:0] corner [3];
      int k;
      corner = '{8'h00, 8'hFF, 8'h00};
      void'($urandom(61));
      e8 = 8'hFF;
      e2 = 2'h3;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      wait_run();
      check("latch8", lat8, 8'hFF);
      check("latch2", {6'h00, lat2}, 8'h03);
      // all bits low, all released with assist, all low again, then two-bit refused bit write
      foreach (corner[i]) begin
         r = '0;
         r.wr = 1'b1;
         r.wdata = corner[i];
         step(r);
      end
      r = '0;
      r.bit_wr = 1'b1;
      r.port_sel = qbp_pkg::PSEL_TWO;
      r.bit_idx = 3'h7;
      step(r);
      pulse(2);
      pulse(12);
      for (k = 0; k < 200; k++) begin
         r = qbp_pkg::qbp_cpu_req_t'(17'($urandom));
         if (k[0])
            {r.bit_wr, r.wr} = 2'b00;
         step(r);
      end
      complete_run();
   end
endmodule
